// >>> hw/ewt_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - mux address wait bit set adds one wait cycle after the address cycle
// - mux address wait only matters for multiplexed accesses
// - write wait code 000 reuses the read wait count
// - write wait codes 001..111 give 0..6 wait cycles
// - setup field gives 0.5..3.5 cycles to strobe from select, or from the end of the address cycles on mux accesses
// - bits 31..21 and 15..13 read zero; software writes zero
// - bit 19 reads zero; software writes zero
// - read wait codes give 0..6, 8, 10, 12, 14, 18, 24 cycles
// - mask bit clear honours external wait, set ignores it
// - hold field gives 0.5..3.5 cycles from strobe off to deselect
module ewt_ctrl
    import ewt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic acc_req_i,
    input wire logic acc_write_i,
    input wire logic acc_mux_i,
    input wire logic ext_wait_i,
    output logic acc_done_o,
    output logic acc_busy_o,
    output logic chip_select_n_o,
    output logic read_strobe_n_o,
    output logic write_strobe_n_o,
    output logic addr_phase_o
);
    ////////////////////////////////////////////////////////////////////////
    // register bus slave
    logic [31:0] area_bus_wait_control;
    logic [31:0] next_cfg;
    logic [31:0] next_rdata;
    logic bus_ack;
    logic next_bus_ack;
    logic hit;

    assign hit = (avs_address_i == EWT_REG_OFS);
    // one wait state on every access; the second cycle completes it
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~bus_ack;

    always_comb begin
        next_bus_ack = (avs_read_i | avs_write_i) & ~bus_ack;
        next_cfg = area_bus_wait_control;
        next_rdata = avs_readdata_o;
        if (avs_write_i && bus_ack && hit) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable_i[b]) begin
                    next_cfg[8*b +: 8] = avs_writedata_i[8*b +: 8];
                end
            end
            // reserved bits never store anything
            next_cfg = next_cfg & EWT_WR_MASK;
        end
        if (avs_read_i && !bus_ack) begin
            next_rdata = hit ? (area_bus_wait_control & EWT_WR_MASK)
                       : EWT_RD_ZERO;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            area_bus_wait_control <= EWT_RST_VAL;
            avs_readdata_o <= 32'h0000_0000;
            bus_ack <= 1'b0;
        end else begin
            area_bus_wait_control <= next_cfg;
            avs_readdata_o <= next_rdata;
            bus_ack <= next_bus_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencer; config is frozen per access so a register write
    // in mid access cannot tear the strobe timing
    ewt_state_t state;
    ewt_state_t next_state;
    logic [31:0] cfg_lat;
    logic [31:0] next_cfg_lat;
    logic wr_lat;
    logic next_wr_lat;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic next_cs_n;
    logic next_rd_n;
    logic next_wr_n;
    logic next_ale;
    logic next_done;
    logic [5:0] setup_load;
    logic [5:0] strobe_load;
    logic [5:0] hold_load;
    logic [4:0] wait_cyc;
    logic wait_hold;

    ewt_timing u_timing (
        .cfg_i(cfg_lat),
        .is_write_i(wr_lat),
        .setup_load_o(setup_load),
        .strobe_load_o(strobe_load),
        .hold_load_o(hold_load),
        .wait_o(wait_cyc)
    );

    // the mask wins even when the wait count is zero
    assign wait_hold = ext_wait_i & ~cfg_lat[EWT_WM_BIT];
    assign acc_busy_o = (state != EWT_IDLE);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cfg_lat = cfg_lat;
        next_wr_lat = wr_lat;
        next_done = 1'b0;
        unique case (state)
            EWT_IDLE: begin
                if (acc_req_i) begin
                    next_cfg_lat = area_bus_wait_control;
                    next_wr_lat = acc_write_i;
                    if (acc_mux_i) begin
                        next_state = EWT_ADDR;
                        next_cnt = EWT_ADDR_LOAD;
                    end else begin
                        next_state = EWT_SETUP;
                        next_cnt = {3'h0, area_bus_wait_control[EWT_SW_LSB +: 2],
                                    1'b0};
                    end
                end
            end
            EWT_ADDR: begin
                next_cnt = cnt - 6'h01;
                if (cnt == 6'h00) begin
                    if (cfg_lat[EWT_MUX_ADDR_WAIT_BIT]) begin
                        next_state = EWT_AWAIT;
                        next_cnt = EWT_AWAIT_LOAD;
                    end else begin
                        next_state = EWT_SETUP;
                        next_cnt = setup_load;
                    end
                end
            end
            EWT_AWAIT: begin
                next_cnt = cnt - 6'h01;
                if (cnt == 6'h00) begin
                    next_state = EWT_SETUP;
                    next_cnt = setup_load;
                end
            end
            EWT_SETUP: begin
                next_cnt = cnt - 6'h01;
                if (cnt == 6'h00) begin
                    next_state = EWT_STRB;
                    next_cnt = strobe_load;
                end
            end
            EWT_STRB: begin
                if (cnt != 6'h00) begin
                    next_cnt = cnt - 6'h01;
                end else if (!wait_hold) begin
                    next_state = EWT_HOLD;
                    next_cnt = hold_load;
                end
            end
            EWT_HOLD: begin
                next_cnt = cnt - 6'h01;
                if (cnt == 6'h00) begin
                    next_state = EWT_IDLE;
                    next_cnt = 6'h00;
                    next_done = 1'b1;
                end
            end
        endcase
        // pins follow the next state so they come straight from flops
        next_cs_n = (next_state == EWT_IDLE);
        next_ale = (next_state == EWT_ADDR);
        next_rd_n = !((next_state == EWT_STRB) && !next_wr_lat);
        next_wr_n = !((next_state == EWT_STRB) && next_wr_lat);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= EWT_IDLE;
            cnt <= 6'h00;
            cfg_lat <= EWT_RST_VAL;
            wr_lat <= 1'b0;
            acc_done_o <= 1'b0;
            chip_select_n_o <= 1'b1;
            read_strobe_n_o <= 1'b1;
            write_strobe_n_o <= 1'b1;
            addr_phase_o <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            cfg_lat <= next_cfg_lat;
            wr_lat <= next_wr_lat;
            acc_done_o <= next_done;
            chip_select_n_o <= next_cs_n;
            read_strobe_n_o <= next_rd_n;
            write_strobe_n_o <= next_wr_n;
            addr_phase_o <= next_ale;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_addr_end;
        state == EWT_ADDR && cnt == 6'h00;
    endsequence

    property p_mux_wait;
        s_addr_end |=> (cfg_lat[EWT_MUX_ADDR_WAIT_BIT] ? state == EWT_AWAIT
                                              : state == EWT_SETUP);
    endproperty
    a_mux_wait: assert property (p_mux_wait)
        else $error("mux address wait not applied");

    property p_no_mux;
        (state == EWT_IDLE && acc_req_i && !acc_mux_i) |=>
            state == EWT_SETUP ##1 state != EWT_AWAIT;
    endproperty
    a_no_mux: assert property (p_no_mux)
        else $error("non-mux access entered address phase");

    property p_ww_fallback;
        (wr_lat && cfg_lat[EWT_WW_LSB +: 3] == 3'h0 &&
         cfg_lat[EWT_WR_LSB +: 4] == 4'h8) |-> wait_cyc == 5'h0A;
    endproperty
    a_ww_fallback: assert property (p_ww_fallback)
        else $error("write wait did not fall back to read wait");

    property p_ww_code;
        (wr_lat && cfg_lat[EWT_WW_LSB +: 3] != 3'h0) |->
            wait_cyc == {2'h0, cfg_lat[EWT_WW_LSB +: 3]} - 5'h01;
    endproperty
    a_ww_code: assert property (p_ww_code)
        else $error("write wait count wrong");

    sequence s_setup_start;
        $rose(state == EWT_SETUP);
    endsequence

    property p_setup;
        s_setup_start |-> cnt == {3'h0, cfg_lat[EWT_SW_LSB +: 2], 1'b0}
            && !chip_select_n_o && read_strobe_n_o && write_strobe_n_o;
    endproperty
    a_setup: assert property (p_setup)
        else $error("strobe setup delay wrong");

    property p_reserved;
        !avs_waitrequest_o && avs_read_i |->
            (avs_readdata_o & 32'hFFE0_E03C) == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits read nonzero");

    property p_bit19;
        area_bus_wait_control[19] == 1'b0;
    endproperty
    a_bit19: assert property (p_bit19)
        else $error("bit 19 stored a value");

    property p_rd_wait;
        (!wr_lat && cfg_lat[EWT_WR_LSB +: 4] == 4'h7) |-> wait_cyc == 5'h08;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait code 0111 not 8 cycles");

    property p_mask;
        (state == EWT_STRB && cnt == 6'h00 && cfg_lat[EWT_WM_BIT]) |=>
            state == EWT_HOLD;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked external wait still stretched strobe");

    property p_hold;
        $rose(state == EWT_HOLD) |-> cnt == {3'h0, cfg_lat[EWT_HW_LSB +: 2],
            1'b0} && read_strobe_n_o && write_strobe_n_o && !chip_select_n_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("strobe hold delay wrong");

    property p_strobe;
        (state == EWT_STRB && cnt == 6'h00 && wait_hold) |=>
            state == EWT_STRB && !(read_strobe_n_o && write_strobe_n_o);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("external wait did not extend strobe");
endmodule
`default_nettype wire

// >>> hw/ewt_pkg.sv
package ewt_pkg;
    // register map and reset contents
    localparam logic [3:0] EWT_REG_OFS = 4'h0;
    localparam logic [31:0] EWT_RST_VAL = 32'h0000_0500;
    localparam logic [31:0] EWT_WR_MASK = 32'h0017_1FC3;
    // field positions
    localparam int EWT_MUX_ADDR_WAIT_BIT = 20;
    localparam int EWT_WW_LSB = 16;
    localparam int EWT_SW_LSB = 11;
    localparam int EWT_WR_LSB = 7;
    localparam int EWT_WM_BIT = 6;
    localparam int EWT_HW_LSB = 0;
    // clk_i ticks at twice the bus rate: one tick is half a bus cycle
    localparam logic [5:0] EWT_ADDR_LOAD = 6'h01;
    localparam logic [5:0] EWT_AWAIT_LOAD = 6'h01;
    localparam logic [31:0] EWT_RD_ZERO = 32'h0000_0000;
    typedef enum logic [5:0] {
        EWT_IDLE = 6'h01,
        EWT_ADDR = 6'h02,
        EWT_AWAIT = 6'h04,
        EWT_SETUP = 6'h08,
        EWT_STRB = 6'h10,
        EWT_HOLD = 6'h20
    } ewt_state_t;
endpackage

// >>> hw/ewt_timing.sv
`timescale 1ns/1ps
`default_nettype none
module ewt_timing
    import ewt_pkg::*;
(
    input wire logic [31:0] cfg_i,
    input wire logic is_write_i,
    output logic [5:0] setup_load_o,
    output logic [5:0] strobe_load_o,
    output logic [5:0] hold_load_o,
    output logic [4:0] wait_o
);
    ////////////////////////////////////////////////////////////////////////
    // read wait code to bus cycles; prohibited codes clamp to the longest
    function automatic logic [4:0] ewt_rd_wait(input logic [3:0] c);
        unique case (c)
            4'h7: ewt_rd_wait = 5'h08;
            4'h8: ewt_rd_wait = 5'h0A;
            4'h9: ewt_rd_wait = 5'h0C;
            4'hA: ewt_rd_wait = 5'h0E;
            4'hB: ewt_rd_wait = 5'h12;
            4'hC, 4'hD, 4'hE, 4'hF: ewt_rd_wait = 5'h18;
            default: ewt_rd_wait = {1'b0, c};
        endcase
    endfunction

    // n.5 bus cycles is 2n+1 ticks, so the counter load is 2n
    function automatic logic [5:0] ewt_half_load(input logic [1:0] c);
        ewt_half_load = {3'h0, c, 1'b0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [2:0] ww;
    assign ww = cfg_i[EWT_WW_LSB +: 3];
    // write code zero falls back to the read wait setting
    assign wait_o = (is_write_i && ww != 3'h0) ? {2'h0, ww - 3'h1}
                  : ewt_rd_wait(cfg_i[EWT_WR_LSB +: 4]);
    // strobe lasts one bus cycle plus the wait cycles
    assign strobe_load_o = {wait_o, 1'b0} + 6'h01;
    assign setup_load_o = ewt_half_load(cfg_i[EWT_SW_LSB +: 2]);
    assign hold_load_o = ewt_half_load(cfg_i[EWT_HW_LSB +: 2]);
endmodule
`default_nettype wire

// >>> bench/ewt_ext_dev.sv
`timescale 1ns/1ps
`default_nettype none
module ewt_ext_dev (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic chip_select_n_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [5:0] busy_ticks_i,
    output logic ext_wait_o
);
    logic strobe_on;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic tog;
    logic next_tog;
    assign strobe_on = !read_strobe_n_i || !write_strobe_n_i;
    ////////////////////////////////////////////////////////////////////////
    // count strobe ticks; the toggle stands in for an undriven wait line
    always_comb begin
        next_tog = ~tog;
        next_cnt = strobe_on ? cnt + 6'h01 : 6'h00;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 6'h00;
            tog <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tog <= next_tog;
        end
    end
    // a slow device holds wait for its first busy ticks of the strobe
    always_comb begin
        if (chip_select_n_i) begin
            ext_wait_o = tog; // not selected: nobody drives the line
        end else begin
            ext_wait_o = strobe_on && (cnt < busy_ticks_i);
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ewt_pkg::*;
;
    logic clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [3:0] avs_address_i, avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, reg_m, q, cfg;
    logic acc_req_i, acc_write_i, acc_mux_i, ext_wait_i, acc_done_o;
    logic acc_busy_o, chip_select_n_o, read_strobe_n_o, write_strobe_n_o;
    logic addr_phase_o;
    logic [5:0] busy;
    int n_fail, checked, seed, cycles;
    int exp_q[$];
    int rd_tab[16] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24, 24, 24, 24};
    ewt_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .acc_req_i(acc_req_i), .acc_write_i(acc_write_i), .acc_mux_i(acc_mux_i),
        .ext_wait_i(ext_wait_i), .acc_done_o(acc_done_o),
        .acc_busy_o(acc_busy_o), .chip_select_n_o(chip_select_n_o),
        .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
        .addr_phase_o(addr_phase_o));
    ewt_ext_dev ext (.clk_i(clk_i), .rst_i(rst_i),
        .chip_select_n_i(chip_select_n_o), .read_strobe_n_i(read_strobe_n_o),
        .write_strobe_n_i(write_strobe_n_o), .busy_ticks_i(busy),
        .ext_wait_o(ext_wait_i));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // a hang shows up as a mismatch, then the normal closing report
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("ERROR %0t: run timed out", $time);
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // one bus cycle; the model register follows mapped writes lane by lane
    task automatic av(input logic wr, input logic [3:0] a,
        input logic [31:0] d, input logic [3:0] be, output logic [31:0] r);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        r = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (wr && a == EWT_REG_OFS) begin
            for (int b = 0; b < 4; b++) begin
                if (be[b]) reg_m[8*b+:8] = d[8*b+:8] & EWT_WR_MASK[8*b+:8];
            end
        end
        @(posedge clk_i);
    endtask
    // one external access; phases are counted in clock ticks
    task automatic run_acc(input logic wr, input logic mux,
        input logic [5:0] bz);
        int pre, str, post, lat, w, ts;
        logic bad, ap, bsy;
        bsy = 1'b0;
        pre = 0;
        str = 0;
        post = 0;
        lat = 0;
        bad = 1'b0;
        ap = 1'b0;
        acc_req_i <= 1'b1;
        acc_write_i <= wr;
        acc_mux_i <= mux;
        busy <= bz;
        @(posedge clk_i);
        acc_req_i <= 1'b0;
        do begin
            @(posedge clk_i);
            lat++;
            if ((wr ? read_strobe_n_o : write_strobe_n_o) !== 1'b1) bad = 1'b1;
            if ((wr ? write_strobe_n_o : read_strobe_n_o) === 1'b0) str++;
            else if (chip_select_n_o === 1'b0 && str == 0) pre++;
            else if (chip_select_n_o === 1'b0) post++;
            if (addr_phase_o === 1'b1) ap = 1'b1;
            // busy must span exactly the selected window
            if (acc_busy_o !== !chip_select_n_o) bsy = 1'b1;
        end while (acc_done_o !== 1'b1 && lat < 300);
        // a run past the limit leaves done low and counts as a mismatch
        chk(acc_done_o, 1'b1, "done pulse");
        chk(bsy, 1'b0, "busy flag");
        w = rd_tab[reg_m[10:7]];
        if (wr && reg_m[18:16] != 3'h0) w = reg_m[18:16] - 1;
        ts = 2 * w + 2;
        if (!reg_m[6] && bz + 1 > ts) ts = bz + 1;
        exp_q.push_back(2 * reg_m[12:11] + 1 + (mux ? 2 + 2 * reg_m[20] : 0));
        exp_q.push_back(ts);
        exp_q.push_back(2 * reg_m[1:0] + 1);
        chk(pre, exp_q.pop_front(), "setup ticks");
        chk(str, exp_q.pop_front(), "strobe ticks");
        chk(post, exp_q.pop_front(), "hold ticks");
        chk(lat, pre + str + post + 1, "latency");
        chk(bad, 1'b0, "wrong strobe");
        chk(ap, mux, "addr phase");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h772A5C34;
        rst_i = 1'b1;
        {avs_read_i, avs_write_i, acc_req_i, acc_write_i, acc_mux_i} = 5'h00;
        avs_address_i = 4'h0;
        avs_byteenable_i = 4'hF;
        avs_writedata_i = 32'h0000_0000;
        busy = 6'h00;
        reg_m = EWT_RST_VAL;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        av(1'b0, EWT_REG_OFS, 32'h0, 4'hF, q);
        chk(q, EWT_RST_VAL, "reset value");
        $display("test reset_value done");
        // deliberate ones in reserved bits, then a single lane write
        av(1'b1, EWT_REG_OFS, 32'hFFFF_FFFF, 4'hF, q);
        av(1'b0, EWT_REG_OFS, 32'h0, 4'hF, q);
        chk(q, reg_m, "all ones");
        chk(q[31:21], 11'h000, "bits 31..21");
        chk(q[15:13], 3'h0, "bits 15..13");
        chk(q[19], 1'b0, "bit 19");
        av(1'b1, EWT_REG_OFS, 32'h0, 4'h2, q);
        av(1'b1, 4'h4, 32'h0, 4'hF, q);
        av(1'b0, 4'h4, 32'h0, 4'hF, q);
        chk(q, 32'h0, "unmapped read");
        av(1'b0, EWT_REG_OFS, 32'h0, 4'hF, q);
        chk(q, reg_m, "lane write");
        $display("test register done");
        // every write code, setup and hold code; read codes 0..12 in turn
        for (int i = 0; i < 48; i++) begin
            cfg = $random(seed) & EWT_WR_MASK;
            cfg[10:7] = 4'(i % 13);
            if (i < 32) begin
                cfg[18:16] = 3'(i % 8);
                cfg[12:11] = 2'(i % 4);
                cfg[1:0] = 2'(i / 8);
            end
            av(1'b1, EWT_REG_OFS, cfg, 4'hF, q);
            run_acc(i < 32 ? i[3] : cfg[2], i < 32 ? i[4] : cfg[3],
                6'($random(seed) & 15));
        end
        $display("test access_timing done");
        wrap_up();
    end
endmodule
`default_nettype wire
